// ### src/eeelpi_pkg.sv
// package of constants and carrier types for the eee low-power-idle mac control block
package eeelpi_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ           = 10;             // i_clk rate
    localparam int US_NS             = 1000;           // one microsecond in ns
    localparam int CYCLES_PER_US     = (US_NS * CLK_MHZ + 999) / 1000;
    localparam int IFG_100_NS        = 960;            // 96 bit times at 100 Mb/s
    localparam int IFG_1000_NS       = 96;             // 96 bit times at 1000 Mb/s
    localparam int IFG_100_CYCLES    = (IFG_100_NS * CLK_MHZ + 999) / 1000;
    localparam int IFG_1000_CYCLES   = (IFG_1000_NS * CLK_MHZ + 999) / 1000;
    localparam int LINK_STABLE_MS    = 1000;           // link up for one second
    localparam int LINK_STABLE_CYCLES = LINK_STABLE_MS * 1000 * CLK_MHZ;
    localparam int GTX_PRE_HALT      = 9;              // gtx edges before halting
    localparam int GTX_PRE_DROP      = 1;              // gtx edges before lpi drops
    localparam int RX_ON_CLOCKS      = 3;              // rx lpi seen active
    localparam int RX_OFF_CLOCKS     = 4;              // rx lpi seen inactive

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EEELPI_SPD_10,
        EEELPI_SPD_100,
        EEELPI_SPD_1000
    } eeelpi_speed_type;

    typedef struct packed {
        logic             energy_eff_enable;
        logic             full_duplex;
        logic             eee_adv_ok;          // both ends advertise eee at this speed
        eeelpi_speed_type speed;
        logic             lpi_txclk_halt_enable;
    } eeelpi_cfg_type;

    typedef struct packed {
        logic pause;
        logic offload;
        logic data;
    } eeelpi_src_type;

endpackage

// ### src/eeelpi_mac_ctrl.sv
// eee low-power-idle control: tx lpi, wake/deferral, source choice, gtx halt, rx lpi decode, counters
//
// Operation
// R1: carrier flag sets on lpi request rise; wake timer on fall clears it.
// R2: wake wait time chosen per speed from a separate value per speed.
// R3: deferring holds while sending or carrier; ifg timer clears it afterwards.
// R4: no frame starts while deferring is set.
// R5: pause wins over offload response and buffered data.
// R6: source choice waits for wake time to end, so late pause wins.
// R7: optional gtx clock halt during lpi, after at least nine clocks.
// R8: gtx clock restarted for at least one cycle before lpi drops.
// R9: tx lpi transition counter, read only, never cleared.
// R10: tx lpi microsecond counter, excludes the wake wait time.
// R11: all four counters run in normal and both suspend states.
// R12: rx lpi active after 3 clocks, inactive after 4 clocks.
// R13: phy gives nine lpi clocks before stopping, one after restart.
// R14: rx lpi start sets flag; interrupt only when its enable is set.
// R15: rx lpi end sets wake flag if enabled; feeds wake status.
// R16: rx decode only with eee, 100/1000, full duplex, advert, link stable.
// R17: rx decode ignores the receiver enable bit.
// R18: rx lpi transition counter, read only, never cleared.
// R19: rx lpi microsecond counter, read only, never cleared.
// R20: wake logic does not gate by power state.
// R21: lpi request waits for frame end; short client pulses ignored.
// R22: after lpi drop, defer wake time plus normal gap.
// R23: all counters wrap to zero.
`timescale 1ns/1ps
module eeelpi_mac_ctrl #(
    parameter int CNT_W       = 32,
    parameter int WAIT_W      = 16,
    parameter int LINK_CYCLES = eeelpi_pkg::LINK_STABLE_CYCLES
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    input  wire eeelpi_pkg::eeelpi_cfg_type i_cfg,
    input  wire logic                       i_link_up,
    input  wire logic [WAIT_W-1:0]          i_wait_us_100,
    input  wire logic [WAIT_W-1:0]          i_wait_us_1000,
    input  wire logic                       i_client_lpi_req,
    input  wire logic                       i_frame_active,
    input  wire eeelpi_pkg::eeelpi_src_type i_src_req,
    input  wire logic                       i_rx_clk,
    input  wire logic                       i_rx_lpi,
    input  wire logic                       i_rx_low_power_irq_enable,
    input  wire logic                       i_rx_lpi_exit_wake_enable,
    input  wire logic                       i_energy_wake_enable,
    input  wire logic                       i_rx_flag_clear,
    input  wire logic                       i_wake_flag_clear,
    input  wire logic                       i_wake_status_clear,
    output logic                            o_tx_lpi,
    output logic                            o_gtx_clk,
    output logic                            o_carrier,
    output logic                            o_deferring,
    output eeelpi_pkg::eeelpi_src_type      o_grant,
    output logic                            o_rx_low_power_flag,
    output logic                            o_rx_lpi_exit_wake_flag,
    output logic                            o_energy_wake_status,
    output logic                            o_rx_lpi_irq,
    output logic                            o_remote_wake_req,
    output logic [CNT_W-1:0]                o_tx_lpi_transitions,
    output logic [CNT_W-1:0]                o_tx_lpi_time_us,
    output logic [CNT_W-1:0]                o_rx_lpi_transitions,
    output logic [CNT_W-1:0]                o_rx_lpi_time_us
);
    import eeelpi_pkg::*;

    // ------------------------------------------------------------
    // decode conditions and microsecond tick
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EEELPI_ACTIVE,
        EEELPI_LPI_RUN,
        EEELPI_LPI_HALT,
        EEELPI_LPI_WAKE
    } eeelpi_state_type;

    localparam int WAKE_W = WAIT_W + 8;

    eeelpi_state_type  state;
    logic [3:0]        gtx_edges;
    logic              gtx_run;
    logic              gtx_rise;
    logic [WAKE_W-1:0] wake_cnt;
    logic              wake_active;
    logic [3:0]        ifg_cnt;
    logic [3:0]        ifg_last;
    logic              busy;
    logic [7:0]        us_cnt;
    logic              us_tick;
    logic [31:0]       link_cnt;
    logic              link_stable;
    logic              decode_en;
    logic              en_s1;
    logic              en_s2;
    logic              rx_filt;
    logic [2:0]        rx_run;
    logic              lvl_s1;
    logic              lvl_s2;
    logic              lvl_d;
    logic              rx_start;
    logic              rx_end;

    // one microsecond strobe shared by both time counters
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            us_cnt <= 8'h00;
        end else if (us_cnt == 8'(CYCLES_PER_US - 1)) begin
            us_cnt <= 8'h00;
        end else begin
            us_cnt <= us_cnt + 8'h01;
        end
    end
    assign us_tick = (us_cnt == 8'(CYCLES_PER_US - 1));

    // link must be up for a full second before rx lpi is trusted
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_cnt    <= 32'h0000_0000;
            link_stable <= 1'b0;
        end else if (!i_link_up) begin
            link_cnt    <= 32'h0000_0000;
            link_stable <= 1'b0;
        end else if (link_cnt == 32'(LINK_CYCLES - 1)) begin
            link_stable <= 1'b1;
        end else begin
            link_cnt <= link_cnt + 32'h0000_0001;
        end
    end

    // receiver enable is deliberately not an input here [R17]; no power-state gating [R20]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            decode_en <= 1'b0;
        end else begin
            decode_en <= i_cfg.energy_eff_enable && i_cfg.full_duplex && i_cfg.eee_adv_ok  // [R16]
                         && (i_cfg.speed == EEELPI_SPD_100 || i_cfg.speed == EEELPI_SPD_1000)
                         && link_stable;
        end
    end

    // ------------------------------------------------------------
    // tx lpi request and gtx clock halting
    // ------------------------------------------------------------
    assign gtx_run  = (state != EEELPI_LPI_HALT);
    assign gtx_rise = gtx_run && !o_gtx_clk;

    // gtx is i_clk divided by two; it only ever stops low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_gtx_clk <= 1'b0;
        end else if (gtx_run) begin
            o_gtx_clk <= !o_gtx_clk;
        end
    end

    // request sampled only between frames, so a pulse inside a frame is lost [R21]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= EEELPI_ACTIVE;
            o_tx_lpi  <= 1'b0;
            gtx_edges <= 4'h0;
        end else begin
            unique case (state)
                EEELPI_ACTIVE: begin
                    gtx_edges <= 4'h0;
                    if (i_client_lpi_req && !i_frame_active && !busy) begin
                        state    <= EEELPI_LPI_RUN;  // [R21]
                        o_tx_lpi <= 1'b1;
                    end
                end
                EEELPI_LPI_RUN: begin
                    if (gtx_rise && gtx_edges != 4'hf) begin
                        gtx_edges <= gtx_edges + 4'h1;
                    end
                    if (!i_client_lpi_req) begin
                        state    <= EEELPI_ACTIVE;   // clock is still running here [R8]
                        o_tx_lpi <= 1'b0;
                    end else if (i_cfg.lpi_txclk_halt_enable && gtx_edges >= 4'(GTX_PRE_HALT) && o_gtx_clk) begin
                        state <= EEELPI_LPI_HALT;    // [R7]
                    end
                end
                EEELPI_LPI_HALT: begin
                    gtx_edges <= 4'h0;
                    if (!i_client_lpi_req) begin
                        state <= EEELPI_LPI_WAKE;
                    end
                end
                EEELPI_LPI_WAKE: begin
                    if (gtx_rise) begin
                        gtx_edges <= gtx_edges + 4'h1;
                    end
                    if (gtx_edges >= 4'(GTX_PRE_DROP)) begin
                        state    <= EEELPI_ACTIVE;   // [R8]
                        o_tx_lpi <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // carrier deferral and inter-frame gap
    // ------------------------------------------------------------
    // wake timer loads the per-speed wait on the lpi drop [R2]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wake_cnt    <= '0;
            wake_active <= 1'b0;
        end else if ((state == EEELPI_LPI_RUN && !i_client_lpi_req)
                     || (state == EEELPI_LPI_WAKE && gtx_edges >= 4'(GTX_PRE_DROP))) begin
            wake_active <= 1'b1;                     // [R1]
            wake_cnt    <= WAKE_W'((i_cfg.speed == EEELPI_SPD_1000 ? i_wait_us_1000 : i_wait_us_100))
                           * WAKE_W'(CYCLES_PER_US); // [R2]
        end else if (wake_active) begin
            if (wake_cnt == '0) begin
                wake_active <= 1'b0;
            end else begin
                wake_cnt <= wake_cnt - WAKE_W'(1);
            end
        end
    end

    // carrier covers the lpi period plus the whole wake wait [R1] [R22]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_carrier <= 1'b0;
        end else if (o_tx_lpi) begin
            o_carrier <= 1'b1;                       // [R1]
        end else if (wake_active && wake_cnt == '0) begin
            o_carrier <= 1'b0;                       // [R1]
        end
    end

    assign busy     = i_frame_active || o_carrier || o_tx_lpi;
    assign ifg_last = (i_cfg.speed == EEELPI_SPD_1000) ? 4'(IFG_1000_CYCLES - 1) : 4'(IFG_100_CYCLES - 1);

    // gap timer starts only when both frame and carrier are gone [R3] [R22]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_deferring <= 1'b0;
            ifg_cnt     <= 4'h0;
        end else if (busy) begin
            o_deferring <= 1'b1;                     // [R3]
            ifg_cnt     <= 4'h0;
        end else if (o_deferring) begin
            if (ifg_cnt >= ifg_last) begin
                o_deferring <= 1'b0;                 // [R3]
            end else begin
                ifg_cnt <= ifg_cnt + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit source choice
    // ------------------------------------------------------------
    // choice is made only once deferral ends, so a pause raised during wake wins [R6]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_grant <= '0;
        end else begin
            o_grant <= '0;
            if (!o_deferring && !busy && o_grant == '0) begin  // [R4] [R6]
                if (i_src_req.pause) begin
                    o_grant.pause <= 1'b1;                     // [R5]
                end else if (i_src_req.offload) begin
                    o_grant.offload <= 1'b1;
                end else if (i_src_req.data) begin
                    o_grant.data <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // rx lpi filter, on the phy receive clock
    // ------------------------------------------------------------
    // the filtered level simply holds while the phy has stopped its clock [R13]
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
        end else begin
            en_s1 <= decode_en;
            en_s2 <= en_s1;
        end
    end

    // a run counter of agreeing samples; level flips at 3 on, 4 off [R12]
    always_ff @(posedge i_rx_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_filt <= 1'b0;
            rx_run  <= 3'h0;
        end else if (!en_s2) begin
            rx_filt <= 1'b0;                         // [R16]
            rx_run  <= 3'h0;
        end else if (i_rx_lpi == rx_filt) begin
            rx_run <= 3'h0;
        end else if (rx_run == (rx_filt ? 3'(RX_OFF_CLOCKS - 1) : 3'(RX_ON_CLOCKS - 1))) begin
            rx_filt <= i_rx_lpi;                     // [R12]
            rx_run  <= 3'h0;
        end else begin
            rx_run <= rx_run + 3'h1;
        end
    end

    // level crossing into i_clk; only lvl_s2 onward is used
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl_s1 <= 1'b0;
            lvl_s2 <= 1'b0;
            lvl_d  <= 1'b0;
        end else begin
            lvl_s1 <= rx_filt;
            lvl_s2 <= lvl_s1;
            lvl_d  <= lvl_s2;
        end
    end
    assign rx_start = lvl_s2 && !lvl_d;
    assign rx_end   = !lvl_s2 && lvl_d;

    // ------------------------------------------------------------
    // rx flags, interrupt and wake; set beats a same-cycle clear
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_low_power_flag     <= 1'b0;
            o_rx_lpi_exit_wake_flag <= 1'b0;
            o_energy_wake_status    <= 1'b0;
        end else begin
            if (rx_start) begin
                o_rx_low_power_flag <= 1'b1;         // [R14]
            end else if (i_rx_flag_clear) begin
                o_rx_low_power_flag <= 1'b0;
            end
            if (rx_end && i_rx_lpi_exit_wake_enable) begin
                o_rx_lpi_exit_wake_flag <= 1'b1;     // [R15]
            end else if (i_wake_flag_clear) begin
                o_rx_lpi_exit_wake_flag <= 1'b0;
            end
            if (o_rx_lpi_exit_wake_flag) begin
                o_energy_wake_status <= 1'b1;        // [R15]
            end else if (i_wake_status_clear) begin
                o_energy_wake_status <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_lpi_irq      <= 1'b0;
            o_remote_wake_req <= 1'b0;
        end else begin
            o_rx_lpi_irq      <= o_rx_low_power_flag && i_rx_low_power_irq_enable;  // [R14]
            o_remote_wake_req <= o_energy_wake_status && i_energy_wake_enable;     // [R15]
        end
    end

    // ------------------------------------------------------------
    // counters: no write or clear path, free wrap, no power gating [R11] [R23]
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_lpi_transitions <= '0;
            o_tx_lpi_time_us     <= '0;
            o_rx_lpi_transitions <= '0;
            o_rx_lpi_time_us     <= '0;
        end else begin
            if (state == EEELPI_ACTIVE && i_client_lpi_req && !i_frame_active && !busy) begin
                o_tx_lpi_transitions <= o_tx_lpi_transitions + CNT_W'(1);  // [R9] [R23]
            end
            if (us_tick && o_tx_lpi) begin
                o_tx_lpi_time_us <= o_tx_lpi_time_us + CNT_W'(1);          // wake wait excluded [R10]
            end
            if (rx_start) begin
                o_rx_lpi_transitions <= o_rx_lpi_transitions + CNT_W'(1);  // [R18]
            end
            if (us_tick && lvl_s2) begin
                o_rx_lpi_time_us <= o_rx_lpi_time_us + CNT_W'(1);          // [R19]
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence lpi_drop_s;
        $fell(o_tx_lpi);
    endsequence

    sequence clk_was_running_s;
        $past(gtx_run) && $past(gtx_run, 2);
    endsequence

    carrier_rise_a: assert property ($rose(o_tx_lpi) |=> o_carrier)  // [R1]
        else $error("carrier not set after lpi request");
    carrier_hold_a: assert property (lpi_drop_s |-> o_carrier)  // [R22]
        else $error("carrier dropped with lpi request");
    grant_defer_a: assert property (o_grant != '0 |-> !$past(o_deferring))  // [R4]
        else $error("grant given while deferring");
    pause_first_a: assert property (o_grant.data || o_grant.offload |-> !$past(i_src_req.pause))  // [R5]
        else $error("pause request not chosen first");
    lpi_after_frame_a: assert property ($rose(o_tx_lpi) |-> !$past(i_frame_active))  // [R21]
        else $error("lpi raised during a frame");
    halt_edges_a: assert property ($rose(state == EEELPI_LPI_HALT) |-> $past(gtx_edges) >= 4'(GTX_PRE_HALT))  // [R7]
        else $error("gtx halted too early");
    restart_drop_a: assert property (lpi_drop_s |-> clk_was_running_s)  // [R8]
        else $error("lpi dropped with gtx stopped");
    tx_count_a: assert property ($rose(o_tx_lpi) |-> o_tx_lpi_transitions == $past(o_tx_lpi_transitions) + CNT_W'(1))  // [R9]
        else $error("tx transition count wrong");
    defer_gap_a: assert property (busy || (o_deferring && ifg_cnt < ifg_last) |=> o_deferring)  // [R3]
        else $error("deferral ended without gap");
    rx_flag_a: assert property (rx_start |=> o_rx_low_power_flag ##1 (o_rx_lpi_irq == $past(i_rx_low_power_irq_enable)))  // [R14]
        else $error("rx lpi flag or interrupt wrong");
    rx_on_filter_a: assert property (@(posedge i_rx_clk) disable iff (!i_rst_n)
        $rose(rx_filt) |-> $past(i_rx_lpi) && $past(i_rx_lpi, 2) && $past(i_rx_lpi, 3))  // [R12]
        else $error("rx lpi accepted too soon");
    rx_off_filter_a: assert property (@(posedge i_rx_clk) disable iff (!i_rst_n)
        $fell(rx_filt) && en_s2 |-> !$past(i_rx_lpi) && !$past(i_rx_lpi, 2)
        && !$past(i_rx_lpi, 3) && !$past(i_rx_lpi, 4))  // [R12]
        else $error("rx lpi released too soon");

endmodule

// ### test/eeelpi_phy_model.sv
// behavioural phy receive side: lpi indication and a receive clock that halts in lpi
`timescale 1ns/1ps
module eeelpi_phy_model (
    input  wire logic i_lpi_req,
    output logic      o_rx_clk,
    output logic      o_rx_lpi
);
    logic run;

    // 160 ns clock, phase unrelated to the mac clock; stands still while halted
    initial begin
        o_rx_clk = 1'b0;
        #37;
        forever begin
            #80;
            if (run) begin
                o_rx_clk = ~o_rx_clk;
            end
        end
    end

    // lpi entry and exit wrapped around the clock halt
    initial begin
        run = 1'b1;
        o_rx_lpi = 1'b0;
        forever begin
            wait (i_lpi_req);
            @(negedge o_rx_clk) o_rx_lpi = 1'b1;
            repeat (12) @(posedge o_rx_clk); // nine or more lpi clocks before halting
            @(negedge o_rx_clk) run = 1'b0;
            wait (!i_lpi_req);
            run = 1'b1;
            repeat (2) @(posedge o_rx_clk); // lpi held after restart
            @(negedge o_rx_clk) o_rx_lpi = 1'b0;
        end
    end
endmodule

// ### test/eeelpi_mac_ctrl_tb.sv
// self-checking bench for the eee low-power-idle mac control block
`timescale 1ns/1ps
module eeelpi_mac_ctrl_tb;
    import eeelpi_pkg::*;
    logic           i_clk, i_rst_n, link_up, client_req, frame_act, phy_req;
    logic           irq_en, wake_en, ewake_en, flag_clr, wflag_clr, stat_clr;
    logic           rx_clk, rx_lpi, tx_lpi, gtx, carrier, defer;
    logic           rx_flag, wake_flag, wake_stat, rx_irq, rwake;
    logic [31:0]    tx_tr, tx_us, rx_tr, rx_us;
    eeelpi_cfg_type cfg;
    eeelpi_src_type src, grant;
    int             errors, checks, n, h;

    // short link-stable count keeps the run brief
    eeelpi_mac_ctrl #(.LINK_CYCLES(20)) dut (
        .i_clk, .i_rst_n, .i_cfg(cfg), .i_link_up(link_up), .i_wait_us_100(16'h000a),
        .i_wait_us_1000(16'h0002), .i_client_lpi_req(client_req), .i_frame_active(frame_act),
        .i_src_req(src), .i_rx_clk(rx_clk), .i_rx_lpi(rx_lpi), .i_rx_low_power_irq_enable(irq_en),
        .i_rx_lpi_exit_wake_enable(wake_en), .i_energy_wake_enable(ewake_en),
        .i_rx_flag_clear(flag_clr), .i_wake_flag_clear(wflag_clr), .i_wake_status_clear(stat_clr),
        .o_tx_lpi(tx_lpi), .o_gtx_clk(gtx), .o_carrier(carrier), .o_deferring(defer),
        .o_grant(grant), .o_rx_low_power_flag(rx_flag), .o_rx_lpi_exit_wake_flag(wake_flag),
        .o_energy_wake_status(wake_stat), .o_rx_lpi_irq(rx_irq), .o_remote_wake_req(rwake),
        .o_tx_lpi_transitions(tx_tr), .o_tx_lpi_time_us(tx_us),
        .o_rx_lpi_transitions(rx_tr), .o_rx_lpi_time_us(rx_us));

    eeelpi_phy_model phy (.i_lpi_req(phy_req), .o_rx_clk(rx_clk), .o_rx_lpi(rx_lpi));

    // mac clock, 100 ns
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic w(input int k);
        repeat (k) @(negedge i_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // lpi with gtx halt, wake wait, gap, then a late three-way source choice
    task automatic t_tx_lpi;
        @(posedge i_clk) client_req <= 1'b1;
        w(2);
        chk(tx_lpi, 1);
        chk(tx_tr, 1);
        w(1);
        chk({carrier, defer}, 2'b11);
        h = gtx;
        repeat (30) begin w(1); h += gtx; end
        chk(h >= 9, 1);
        chk(gtx, 0);
        @(posedge i_clk) begin client_req <= 1'b0; src <= 3'b111; end
        h = 0;
        n = 0;
        while (tx_lpi === 1'b1 && n < 10) begin h += gtx; n++; w(1); end
        chk(h > 0, 1);
        n = 0;
        while (carrier === 1'b1 && n < 40) begin chk(grant, 0); n++; w(1); end
        chk(n >= 19 && n <= 23, 1);
        n = 0;
        while (defer === 1'b1 && n < 10) begin chk(grant, 0); n++; w(1); end
        chk(n >= 1 && n <= 3, 1);
        n = 0;
        while (grant === 3'b000 && n < 4) begin n++; w(1); end
        chk(grant, 3'b100);
        @(posedge i_clk) begin frame_act <= 1'b1; src <= 3'b000; end
        @(posedge i_clk) frame_act <= 1'b0;
        chk(tx_us != 0, 1);
    endtask

    // a client pulse inside a frame leaves no trace
    task automatic t_short_req;
        @(posedge i_clk) begin frame_act <= 1'b1; client_req <= 1'b1; end
        w(3);
        @(posedge i_clk) client_req <= 1'b0;
        @(posedge i_clk) frame_act <= 1'b0;
        w(5);
        chk({tx_lpi, carrier}, 0);
        chk(tx_tr, 1);
    endtask

    // 100 mb/s with no gtx halt: five-fold wake wait and a ten-cycle gap
    task automatic t_tx_100;
        @(posedge i_clk) begin cfg <= '{1'b1, 1'b1, 1'b1, EEELPI_SPD_100, 1'b0}; client_req <= 1'b1; end
        w(30);
        chk(tx_lpi, 1);
        chk(tx_tr, 2);
        h = gtx;
        w(1);
        chk(gtx, !h);
        @(posedge i_clk) client_req <= 1'b0;
        w(1);
        n = 0;
        while (carrier === 1'b1 && n < 200) begin chk(grant, 0); n++; w(1); end
        chk(n >= 100 && n <= 104, 1);
        n = 0;
        while (defer === 1'b1 && n < 20) begin n++; w(1); end
        chk(n >= 10 && n <= 12, 1);
    endtask

    // rx lpi entry and exit, irq masking, clears
    task automatic t_rx_lpi;
        @(posedge i_clk) phy_req <= 1'b1;
        w(40);
        chk({rx_flag, rx_irq}, 2'b11);
        chk(rx_tr, 1);
        @(posedge i_clk) irq_en <= 1'b0;
        w(3);
        chk({rx_flag, rx_irq}, 2'b10);
        @(posedge i_clk) begin irq_en <= 1'b1; phy_req <= 1'b0; end
        w(40);
        chk({wake_flag, wake_stat, rwake}, 3'b111);
        chk(rx_us != 0, 1);
        // status keeps setting while the wake flag is up, so clear the flag first
        @(posedge i_clk) begin flag_clr <= 1'b1; wflag_clr <= 1'b1; end
        @(posedge i_clk) begin flag_clr <= 1'b0; wflag_clr <= 1'b0; stat_clr <= 1'b1; end
        @(posedge i_clk) stat_clr <= 1'b0;
        w(3);
        chk({rx_flag, rx_irq, wake_flag, wake_stat}, 0);
    endtask

    // no decode at 10 mb/s
    task automatic t_rx_gate;
        @(posedge i_clk) cfg.speed <= EEELPI_SPD_10;
        @(posedge i_clk) phy_req <= 1'b1;
        w(40);
        chk(rx_flag, 0);
        chk(rx_tr, 1);
    endtask

    // the whole run needs well under 500 us
    initial begin
        #500us;
        errors++;
        finish_test;
    end

    initial begin
        i_rst_n = 1'b0; link_up = 1'b1; client_req = 1'b0; frame_act = 1'b0; phy_req = 1'b0;
        irq_en = 1'b1; wake_en = 1'b1; ewake_en = 1'b1; flag_clr = 1'b0; wflag_clr = 1'b0;
        stat_clr = 1'b0; src = 3'b000; errors = 0; checks = 0;
        cfg = '{1'b1, 1'b1, 1'b1, EEELPI_SPD_1000, 1'b1};
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        w(1);
        chk({tx_lpi, carrier, defer, grant, rx_flag, wake_flag, wake_stat}, 0);
        chk(tx_tr | tx_us | rx_tr | rx_us, 0);
        t_tx_lpi;
        t_short_req;
        t_tx_100;
        t_rx_lpi;
        t_rx_gate;
        finish_test;
    end
endmodule
